/* design/pdct_pkg.sv */
// package: register map, field positions and reset values of the timer
package pdct_pkg;

    // ========================================================
    // register indices and byte addresses (byte = 4 * index)
    localparam logic [7:0]  IDX_PRESCALE = 8'hd2;
    localparam logic [7:0]  IDX_COUNT    = 8'hd3;
    localparam logic [7:0]  IDX_CSR      = 8'hd4;
    localparam logic [11:0] ADDR_PRESCALE = {2'b00, IDX_PRESCALE, 2'b00};
    localparam logic [11:0] ADDR_COUNT    = {2'b00, IDX_COUNT, 2'b00};
    localparam logic [11:0] ADDR_CSR      = {2'b00, IDX_CSR, 2'b00};

    // ========================================================
    // control/status field positions
    localparam int CSR_ZERO_FLAG = 7;
    localparam int CSR_IRQ_EN    = 6;
    localparam int CSR_PIN_DIR   = 5;
    localparam int CSR_PIN_DATA  = 4;
    localparam int CSR_PS_RUN    = 3;
    localparam int CSR_TAP_HI    = 2;
    localparam int CSR_TAP_LO    = 0;

    // ========================================================
    // reset values and timing
    localparam logic [7:0] RST_COUNT    = 8'hff;
    localparam logic [6:0] RST_PRESCALE = 7'h7f;
    localparam logic [7:0] RST_CSR      = 8'h00;
    localparam int         INT_CLK_DIV  = 12;

    // ========================================================
    // operating modes decoded from direction and data select
    typedef enum logic [2:0] {
        PDCT_MODE_EVENT = 3'b001,
        PDCT_MODE_GATED = 3'b010,
        PDCT_MODE_OUT   = 3'b100
    } pdct_mode_e;

endpackage

/* design/pdct_sync.sv */
// two-flop synchroniser for the count pin
`timescale 1ns/10ps
`default_nettype none

module pdct_sync (
    input  wire logic pclk,    // system clock
    input  wire logic presetn, // async reset, active low
    input  wire logic d_i,     // asynchronous level
    output logic      q_o      // synchronised level
);

    logic meta_q;

    // =======================================================
    // first flop is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule // pdct_sync

`default_nettype wire

/* design/pdct_div12.sv */
// internal clock divider: one-cycle tick every DIV cycles
`timescale 1ns/10ps
`default_nettype none

module pdct_div12 #(
    parameter int DIV = pdct_pkg::INT_CLK_DIV // division ratio
) (
    input  wire logic pclk,    // system clock
    input  wire logic presetn, // async reset, active low
    output logic      tick_o   // one-cycle pulse every DIV clocks
);

    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;

    // =======================================================
    // free running modulo counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= (cnt_q == LAST) ? '0 : W'(cnt_q + 1'b1);
            tick_o <= (cnt_q == LAST);
        end
    end

endmodule // pdct_div12

`default_nettype wire

/* design/pdct_timer.sv */
// prescaled 8-bit down counter timer with APB register slave
//
// Functional notes
// R1: 8-bit counter decrements on tap, read/writable
// R2: decrement to zero sets zero flag
// R3: irq when flag set and irq enabled
// R4: irq output usable as wait wakeup
// R5: 7-bit prescaler counts down on input
// R6: tap_select picks counter clock tap
// R7: tap codes give factors 1 to 128
// R8: run low forces prescaler 7Fh, stops counter
// R9: prescaler writable 0..7Fh while running
// R10: mode from direction and data select
// R11: gated mode counts ticks while pin high
// R12: event mode counts pin rising edges
// R13: output mode drives pin, uses ticks
// R14: output latch transparent while flag high
// R15: writing 00h or bit7 sets flag
// R16: software clears flag during service
// R17: reset values FFh, 7Fh, 00h
// R18: counter write beats coincident zero decrement
// R19: counter and prescaler read live values
// R20: control/status bit layout
// R21: prescaler bit 7 reads zero
// R22: counter wraps to FFh and continues
`timescale 1ns/10ps
`default_nettype none

module pdct_timer #(
    parameter int CLK_DIV = pdct_pkg::INT_CLK_DIV // internal clock divider
) (
    input  wire logic        pclk,      // system clock, 250 MHz
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [11:0] paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error, unmapped address
    input  wire logic        pin_i,     // count pin level in
    output logic             pin_o,     // count pin level out
    output logic             pin_oe_n,  // count pin drive enable, low
    output logic             timer_irq  // zero interrupt / wake request
);

    // =======================================================
    // state
    logic [7:0] count_q;
    logic [6:0] ps_q;
    logic       zero_flag_q;
    logic       irq_en_q;
    logic       dir_q;
    logic       dsel_q;
    logic       run_q;
    logic [2:0] tap_q;
    logic       out_latch_q;
    logic       pin_s;
    logic       pin_d_q;
    logic       tick;
    logic [31:0] rdata_q;
    pdct_pkg::pdct_mode_e mode;

    // =======================================================
    // helpers
    // rising edge of the selected tap across one prescaler step
    function automatic logic tap_rise(input logic [6:0] o,
                                      input logic [6:0] n,
                                      input logic [2:0] s);
        logic [2:0] b;
        b = 3'(s - 3'd1);
        if (s == 3'd0) begin
            tap_rise = 1'b1; // factor 1: prescaler input
        end else begin
            tap_rise = !o[b] && n[b];
        end
    endfunction

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a == r);
    endfunction

    // =======================================================
    // submodules
    pdct_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_i     (pin_i),
        .q_o     (pin_s)
    );

    pdct_div12 #(
        .DIV (CLK_DIV)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_o  (tick)
    );

    // =======================================================
    // apb decode
    logic setup_ph;
    logic acc_wr;
    logic mapped;
    logic cnt_wr;
    logic ps_wr;
    logic csr_wr;

    assign setup_ph = psel && !penable;
    assign acc_wr   = psel && penable && pwrite;
    assign mapped   = hit(paddr, pdct_pkg::ADDR_PRESCALE) ||
                      hit(paddr, pdct_pkg::ADDR_COUNT) ||
                      hit(paddr, pdct_pkg::ADDR_CSR);
    assign cnt_wr   = acc_wr && hit(paddr, pdct_pkg::ADDR_COUNT);
    assign ps_wr    = acc_wr && hit(paddr, pdct_pkg::ADDR_PRESCALE);
    assign csr_wr   = acc_wr && hit(paddr, pdct_pkg::ADDR_CSR);
    assign pready   = 1'b1;                 // zero wait states
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = rdata_q;

    // =======================================================
    // mode decode and prescaler input event
    always_comb begin
        if (dir_q) begin
            mode = pdct_pkg::PDCT_MODE_OUT;         // [R10] [R13]
        end else if (dsel_q) begin
            mode = pdct_pkg::PDCT_MODE_GATED;       // [R10]
        end else begin
            mode = pdct_pkg::PDCT_MODE_EVENT;       // [R10]
        end
    end

    logic pin_rise;
    logic ps_ev;
    logic [6:0] ps_dec;
    logic cnt_tick;
    logic dec_to_zero;

    assign pin_rise = pin_s && !pin_d_q;

    // pick the prescaler clock source for the mode
    always_comb begin
        case (mode)
            pdct_pkg::PDCT_MODE_EVENT: ps_ev = pin_rise;      // [R12]
            pdct_pkg::PDCT_MODE_GATED: ps_ev = tick && pin_s; // [R11]
            pdct_pkg::PDCT_MODE_OUT:   ps_ev = tick;          // [R13]
            default:                   ps_ev = 1'b0;
        endcase
    end

    assign ps_dec      = 7'(ps_q - 7'd1);                    // [R5]
    assign cnt_tick    = run_q && ps_ev && !ps_wr &&
                         tap_rise(ps_q, ps_dec, tap_q);      // [R6] [R7]
    assign dec_to_zero = cnt_tick && (count_q == 8'h01);

    // =======================================================
    // pin history for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_q <= 1'b0;
        end else begin
            pin_d_q <= pin_s;
        end
    end

    // =======================================================
    // prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_q <= pdct_pkg::RST_PRESCALE;              // [R17]
        end else if (!run_q) begin
            ps_q <= pdct_pkg::RST_PRESCALE;              // [R8]
        end else if (ps_wr) begin
            ps_q <= pwdata[6:0];                         // [R9]
        end else if (ps_ev) begin
            ps_q <= ps_dec;                              // [R5]
        end
    end

    // =======================================================
    // counter; write beats the decrement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= pdct_pkg::RST_COUNT;              // [R17]
        end else if (cnt_wr) begin
            count_q <= pwdata[7:0];                      // [R1] [R18]
        end else if (cnt_tick) begin
            count_q <= 8'(count_q - 8'd1);               // [R1] [R22]
        end
    end

    // =======================================================
    // control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= pdct_pkg::RST_CSR[pdct_pkg::CSR_IRQ_EN]; // [R17]
            dir_q    <= pdct_pkg::RST_CSR[pdct_pkg::CSR_PIN_DIR];
            dsel_q   <= pdct_pkg::RST_CSR[pdct_pkg::CSR_PIN_DATA];
            run_q    <= pdct_pkg::RST_CSR[pdct_pkg::CSR_PS_RUN];
            tap_q    <= pdct_pkg::RST_CSR[pdct_pkg::CSR_TAP_HI:
                                          pdct_pkg::CSR_TAP_LO];
        end else if (csr_wr) begin
            irq_en_q <= pwdata[pdct_pkg::CSR_IRQ_EN];    // [R20]
            dir_q    <= pwdata[pdct_pkg::CSR_PIN_DIR];
            dsel_q   <= pwdata[pdct_pkg::CSR_PIN_DATA];
            run_q    <= pwdata[pdct_pkg::CSR_PS_RUN];
            tap_q    <= pwdata[pdct_pkg::CSR_TAP_HI:pdct_pkg::CSR_TAP_LO];
        end
    end

    // =======================================================
    // zero flag: any set beats a software clear
    logic flag_set;
    assign flag_set = (dec_to_zero && !cnt_wr) ||             // [R2] [R18]
                      (cnt_wr && pwdata[7:0] == 8'h00) ||     // [R15]
                      (csr_wr && pwdata[pdct_pkg::CSR_ZERO_FLAG]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_flag_q <= pdct_pkg::RST_CSR[pdct_pkg::CSR_ZERO_FLAG];
        end else if (flag_set) begin
            zero_flag_q <= 1'b1;                          // [R2] [R15]
        end else if (csr_wr) begin
            zero_flag_q <= 1'b0;                          // [R16]
        end
    end

    // =======================================================
    // output latch follows data select while flag high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch_q <= 1'b0;
        end else if (zero_flag_q) begin
            out_latch_q <= dsel_q;                        // [R14]
        end
    end

    assign pin_o     = out_latch_q;                       // [R13]
    assign pin_oe_n  = !dir_q;                            // [R10]
    // level request, also usable to leave wait state
    assign timer_irq = zero_flag_q && irq_en_q;           // [R3] [R4]

    // =======================================================
    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            if (hit(paddr, pdct_pkg::ADDR_COUNT)) begin
                rdata_q <= {24'h00_0000, count_q};        // [R19]
            end else if (hit(paddr, pdct_pkg::ADDR_PRESCALE)) begin
                rdata_q <= {25'h000_0000, ps_q};          // [R19] [R21]
            end else if (hit(paddr, pdct_pkg::ADDR_CSR)) begin
                rdata_q <= {24'h00_0000, zero_flag_q, irq_en_q, dir_q,
                            dsel_q, run_q, tap_q};        // [R20]
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // =======================================================
    // assertions
    sequence s_flag_low2;
        !zero_flag_q ##1 !zero_flag_q;
    endsequence

    property p_zero_set;
        @(posedge pclk) disable iff (!presetn)
        (dec_to_zero && !cnt_wr) |=> zero_flag_q && count_q == 8'h00;
    endproperty
    a_zero_set: assert property (p_zero_set) // [R2]
        else $error("decrement to zero did not set flag");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (flag_set && irq_en_q && !csr_wr) |=> timer_irq;
    endproperty
    a_irq: assert property (p_irq) // [R3]
        else $error("irq does not follow flag and enable");

    property p_dec;
        @(posedge pclk) disable iff (!presetn)
        (cnt_tick && !cnt_wr) |=> count_q == 8'($past(count_q) - 8'd1);
    endproperty
    a_dec: assert property (p_dec) // [R1]
        else $error("counter did not decrement by one");

    property p_stopped;
        @(posedge pclk) disable iff (!presetn)
        (!run_q && !cnt_wr) |=> ps_q == 7'h7f && $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) // [R8]
        else $error("stopped timer moved");

    property p_wr_zero;
        @(posedge pclk) disable iff (!presetn)
        (cnt_wr && pwdata[7:0] == 8'h00) |=> zero_flag_q;
    endproperty
    a_wr_zero: assert property (p_wr_zero) // [R15]
        else $error("writing zero did not set flag");

    property p_wr_wins;
        @(posedge pclk) disable iff (!presetn)
        (cnt_wr && dec_to_zero) |=> count_q == $past(pwdata[7:0]) &&
            (zero_flag_q == $past(zero_flag_q) || count_q == 8'h00);
    endproperty
    a_wr_wins: assert property (p_wr_wins) // [R18]
        else $error("decrement beat counter write");

    property p_latch_hold;
        @(posedge pclk) disable iff (!presetn)
        s_flag_low2 |-> $stable(out_latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) // [R14]
        else $error("output latch moved while flag low");

    property p_latch_copy;
        @(posedge pclk) disable iff (!presetn)
        zero_flag_q |=> out_latch_q == $past(dsel_q);
    endproperty
    a_latch_copy: assert property (p_latch_copy) // [R14]
        else $error("output latch not transparent");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (cnt_tick && !cnt_wr && count_q == 8'h00) |=> count_q == 8'hff;
    endproperty
    a_wrap: assert property (p_wrap) // [R22]
        else $error("counter did not wrap to ff");

endmodule // pdct_timer

`default_nettype wire

/* tb/pdct_pin_model.sv */
// external source and load on the count pin
`timescale 1ns/10ps
`default_nettype none

module pdct_pin_model (
    input  wire logic ext_level, // level offered by the outside source
    input  wire logic pin_o,     // level driven by the timer
    input  wire logic pin_oe_n,  // timer drive enable, low
    output logic      pin_i      // resolved pin level
);
    // ========================================================
    // wire resolution: the timer wins while it drives
    assign pin_i = pin_oe_n ? ext_level : pin_o;
endmodule // pdct_pin_model

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the prescaled down counter timer
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        pclk, presetn, psel, penable, pwrite, ext_level;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pin_i, pin_o, pin_oe_n, timer_irq, err;
    int          num_errors, tests_run;

    // ========================================================
    // design and pin partner
    pdct_timer #(.CLK_DIV(4)) u_pdct_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .timer_irq(timer_irq));
    pdct_pin_model u_pdct_pin_model (
        .ext_level(ext_level), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_i(pin_i));

    // ========================================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #80000;
        num_errors++;
        final_report();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // apb transfer: setup, access held until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // n rising edges on the pin, each long enough for the synchroniser
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_level <= 1'b1;
            wait_clk(4);
            ext_level <= 1'b0;
            wait_clk(4);
        end
    endtask

    // ========================================================
    // scenarios
    task automatic t_reset;
        apb(1'b0, pdct_pkg::ADDR_PRESCALE, 32'h0);
        check(rd, 32'h0000007f);
        apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
        check(rd, 32'h000000ff);
        apb(1'b0, pdct_pkg::ADDR_CSR, 32'h0);
        check(rd, 32'h00000000);
        check({pin_oe_n, timer_irq}, 2'b10);
        apb(1'b1, pdct_pkg::ADDR_PRESCALE, 32'h10);
        apb(1'b0, pdct_pkg::ADDR_PRESCALE, 32'h0);
        check(rd, 32'h0000007f);
        pulse(2);
        apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
        check(rd, 32'h000000ff);
        apb(1'b0, 12'h000, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask

    // tap t: counter steps after exactly 2^t pin edges from 7f
    task automatic t_taps;
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, pdct_pkg::ADDR_CSR, 32'h00);
            apb(1'b1, pdct_pkg::ADDR_COUNT, 32'h40);
            apb(1'b1, pdct_pkg::ADDR_CSR, 32'h08 | t);
            pulse((1 << t) - 1);
            apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
            check(rd, 32'h40);
            pulse(1);
            apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
            check(rd, 32'h3f);
            apb(1'b0, pdct_pkg::ADDR_PRESCALE, 32'h0);
            check(rd, 32'h7f - (1 << t));
        end
        apb(1'b1, pdct_pkg::ADDR_PRESCALE, 32'h85);
        apb(1'b0, pdct_pkg::ADDR_PRESCALE, 32'h0);
        check(rd, 32'h05);
    endtask

    // count to zero, flag, interrupt masking, wrap
    task automatic t_zero;
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'h08);
        apb(1'b1, pdct_pkg::ADDR_COUNT, 32'h02);
        pulse(2);
        apb(1'b0, pdct_pkg::ADDR_CSR, 32'h0);
        check(rd, 32'h88);
        check(timer_irq, 1'b0);
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'hc8);
        wait_clk(2);
        check(timer_irq, 1'b1);
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'h48);
        wait_clk(2);
        check(timer_irq, 1'b0);
        pulse(1);
        apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
        check(rd, 32'hff);
        apb(1'b1, pdct_pkg::ADDR_COUNT, 32'h00);
        apb(1'b0, pdct_pkg::ADDR_CSR, 32'h0);
        check(rd, 32'hc8);
        check(timer_irq, 1'b1);
    endtask

    // gated mode counts ticks only while the pin is high
    task automatic t_gated;
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'h18);
        apb(1'b1, pdct_pkg::ADDR_COUNT, 32'h80);
        wait_clk(60);
        apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
        check(rd, 32'h80);
        @(posedge pclk);
        ext_level <= 1'b1;
        wait_clk(60);
        ext_level <= 1'b0;
        wait_clk(6);
        apb(1'b0, pdct_pkg::ADDR_COUNT, 32'h0);
        // 60 gated cycles hold exactly 15 ticks of the divide-by-4
        check(rd, 32'h71);
    endtask

    // output mode: latch follows data only while the flag is high
    task automatic t_output;
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'hb8);
        wait_clk(4);
        check({pin_oe_n, pin_i}, 2'b01);
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'h28);
        wait_clk(4);
        check(pin_i, 1'b1);
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'ha8);
        wait_clk(4);
        check(pin_i, 1'b0);
        apb(1'b1, pdct_pkg::ADDR_CSR, 32'h38);
        apb(1'b1, pdct_pkg::ADDR_COUNT, 32'h03);
        check(pin_i, 1'b0);
        wait_clk(60);
        apb(1'b0, pdct_pkg::ADDR_CSR, 32'h0);
        check(rd[7], 1'b1);
        wait_clk(4);
        check(pin_i, 1'b1);
    endtask

    task automatic final_report;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin
        num_errors = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_level = 1'b0;
        wait_clk(16);
        presetn <= 1'b1;
        t_reset();
        t_taps();
        t_zero();
        t_gated();
        t_output();
        final_report();
    end
endmodule // testbench

`default_nettype wire
